// File: recorder_pkg.sv
// Purpose: Shared constants and types for the voice recorder mode sequencer.
// Assumes: 20 MHz system clock; 10 address lines, the top two select mode use.
// Notes: One row of the message array is the unit of the address pointer.

package recorder_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Address lines and mode bits
	localparam int ADDR_W = 10;
	localparam int MODE_W = 7;
	localparam int TOP_HI_BIT = 9;
	localparam int TOP_LO_BIT = 8;
	localparam int CUE_BIT = 0;
	localparam int MERGE_BIT = 1;
	localparam int RSV_BIT = 2;
	localparam int LOOP_BIT = 3;
	localparam int CHAIN_BIT = 4;
	localparam int LEVEL_BIT = 5;
	localparam int BUTTON_BIT = 6;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int ROW_TIME_MS = 100;
	localparam int ROW_CYCLES = ROW_TIME_MS * 1000000 / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// APB register map
	localparam int PADDR_W = 8;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CONFIG_OFS = 8'h04;
	localparam logic [9:0] ROW_LAST_RST = 10'h3FF;
	localparam int STAT_PTR_LSB = 0;
	localparam int STAT_RUN_BIT = 16;
	localparam int STAT_PLAY_BIT = 17;
	localparam int STAT_CUE_BIT = 18;
	localparam int STAT_EOM_BIT = 19;
	localparam int STAT_OVF_BIT = 20;
	localparam int STAT_SLEEP_BIT = 21;
	localparam int STAT_MODEUSE_BIT = 22;
	localparam int STAT_MODES_LSB = 24;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_CUE = 2'b10
	} seq_state_t;

endpackage

// File: marker_bus_if.sv
// Purpose: Carries end-marker reads and writes from the sequencer to the store.
// Assumes: One access port; read is combinational from the addressed row.
// Notes: The sequencer owns the address and write strobe.

interface marker_bus_if #(parameter int ADDR_W = recorder_pkg::ADDR_W);
	logic [ADDR_W-1:0] addr;
	logic wr_en;
	logic wr_val;
	logic rd_val;
	modport ctrl (output addr, output wr_en, output wr_val, input rd_val);
	modport store (input addr, input wr_en, input wr_val, output rd_val);
endinterface

// File: marker_store.sv
// Purpose: One end-marker flag per message row.
// Assumes: Rows beyond DEPTH are never addressed.
// Notes: Flags are volatile here; the analog array itself is outside this block.

module marker_store #(
	parameter int DEPTH = 1 << recorder_pkg::ADDR_W
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	marker_bus_if.store mk
);
	typedef struct packed {
		logic [DEPTH-1:0] marks;
	} store_state_t;

	store_state_t st;
	store_state_t next_st;

	always_comb begin
		next_st = st;
		if (mk.wr_en) begin
			next_st.marks[mk.addr] = mk.wr_val;
		end
	end

	assign mk.rd_val = st.marks[mk.addr];

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: strobe_edges.sv
// Purpose: Edge detection on the start strobe.
// Assumes: Strobe is synchronous to mclk_i and idles high.
// Notes: Pulses are combinational and last one clock.

module strobe_edges (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic strobe_n_i,
	output logic fall_o,
	output logic rise_o
);
	typedef struct packed {
		logic prev;
	} edge_state_t;

	edge_state_t st;
	edge_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.prev = strobe_n_i;
	end

	assign fall_o = st.prev & ~strobe_n_i;
	assign rise_o = ~st.prev & strobe_n_i;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: voice_recorder_mode_control.sv
// Purpose: Mode decode and message pointer sequencing for a record/playback device.
// Assumes: All pins synchronous to mclk_i; one row elapses every ROW_CYCLES clocks.
// Notes: Stop input dominates the strobe; a strobe fall dominates row progress.
//
// The register offsets and the APB slave port were chosen for this implementation.

// How it works
// - Both top address lines high at strobe fall: low lines are mode bits.
// - First operation in mode use starts at row zero.
// - Direction change (not button mode) or the stop input clears the pointer.
// - Modes are sampled at each strobe fall and held until the next.
// - Cue mode: each strobe fall in playback skips the pointer to the next message.
// - Merge mode: consecutive recordings share one end marker at the end.
// - Loop mode: playback from row zero repeats, wrapping after its end.
// - Loop mode wraps at memory end without flagging overflow.
// - Pointer resets at an end marker unless chain mode or button mode keeps it going.
// - Strobe is edge-started for playback, level-held for recording.
// - Level strobe mode: fall starts playback at row zero, rise stops it.
// - Level strobe mode restarts from zero unless chain mode continues.
// - Button mode powers down after each cycle once strobe is high.
// - Button mode: strobe starts/pauses, stop input resets, run shown high.
// - Button mode pause keeps the pointer in playback, steps it past the new marker in recording; next press resumes there.
// - Button mode stop pulse ends the cycle and zeroes the pointer.
// - Button mode run indicator is high exactly while operating.
// - Play/record select is captured at strobe fall, high meaning playback.
module voice_recorder_mode_control #(
	parameter int ROW_CYCLES = recorder_pkg::ROW_CYCLES,
	parameter int DEPTH = 1 << recorder_pkg::ADDR_W
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [recorder_pkg::ADDR_W-1:0] addr_i,
	input wire logic start_strobe_n_i,
	input wire logic stop_reset_in_i,
	input wire logic play_record_select_i,
	output logic end_marker_out_o,
	output logic overflow_out_n_o,
	output logic power_down_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [recorder_pkg::PADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	localparam int AW = recorder_pkg::ADDR_W;

	typedef struct packed {
		recorder_pkg::seq_state_t fsm;
		logic [AW-1:0] ptr;
		logic [AW-1:0] mem_last;
		logic [recorder_pkg::MODE_W-1:0] modes;
		logic mode_use;
		logic play;
		logic dir_known;
		logic asleep;
		logic eom_hit;
		logic ovf;
		logic [31:0] tick;
		logic eom_o;
		logic ovf_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;
	marker_bus_if #(.ADDR_W(AW)) mk ();
	logic fall;
	logic rise;
	logic bmode;
	logic mu;
	logic row_tick;
	logic at_end;
	logic [AW-1:0] ptr_inc;

	////////////////////////////////////////////////////////////////////////////
	// Leaf blocks

	strobe_edges u_edges (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.strobe_n_i(start_strobe_n_i),
		.fall_o(fall),
		.rise_o(rise)
	);

	marker_store #(.DEPTH(DEPTH)) u_store (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.mk(mk)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	assign bmode = st.mode_use & st.modes[recorder_pkg::BUTTON_BIT];
	assign mu = addr_i[recorder_pkg::TOP_HI_BIT] & addr_i[recorder_pkg::TOP_LO_BIT];
	assign row_tick = (st.fsm == recorder_pkg::ST_RUN) && (st.tick == 32'(ROW_CYCLES - 1));
	assign at_end = (st.ptr == st.mem_last);
	assign ptr_inc = at_end ? '0 : st.ptr + 1'b1;
	// While idle off row zero the store looks one row back, where a merge would erase a marker
	assign mk.addr = (st.fsm == recorder_pkg::ST_IDLE && st.ptr != '0) ? st.ptr - 1'b1 : st.ptr;

	always_comb begin
		next_st = st;
		mk.wr_en = 1'b0;
		mk.wr_val = 1'b0;
		if (st.fsm == recorder_pkg::ST_RUN) begin
			next_st.tick = row_tick ? '0 : st.tick + 32'h00000001;
		end
		if (stop_reset_in_i) begin
			if (st.fsm == recorder_pkg::ST_RUN && !st.play) begin
				mk.wr_en = 1'b1;
				mk.wr_val = 1'b1;
			end
			next_st.fsm = recorder_pkg::ST_IDLE;
			next_st.ptr = '0;
			next_st.dir_known = 1'b0;
			next_st.ovf = 1'b0;
		end else if (fall) begin
			next_st.play = play_record_select_i;
			next_st.mode_use = mu;
			next_st.modes = mu ? addr_i[recorder_pkg::MODE_W-1:0] : '0;
			next_st.eom_hit = 1'b0;
			next_st.tick = '0;
			if (mu && addr_i[recorder_pkg::BUTTON_BIT]) begin
				if (st.fsm == recorder_pkg::ST_RUN && bmode) begin
					next_st.fsm = recorder_pkg::ST_IDLE;
					if (!st.play) begin
						mk.wr_en = 1'b1;
						mk.wr_val = 1'b1;
						next_st.ptr = ptr_inc;
					end
				end else begin
					next_st.fsm = recorder_pkg::ST_RUN;
					next_st.dir_known = 1'b1;
					next_st.ovf = 1'b0;
					// Direction change keeps the pointer here, unlike other modes
					if (st.ovf || !st.dir_known) begin
						next_st.ptr = '0;
					end else if (!play_record_select_i && addr_i[recorder_pkg::MERGE_BIT]
						&& st.ptr != '0 && mk.rd_val) begin
						mk.wr_en = 1'b1;
						next_st.ptr = st.ptr - 1'b1;
					end
				end
			end else begin
				next_st.ovf = 1'b0;
				next_st.dir_known = 1'b1;
				next_st.fsm = (play_record_select_i && mu && addr_i[recorder_pkg::CUE_BIT])
					? recorder_pkg::ST_CUE : recorder_pkg::ST_RUN;
				if (!mu) begin
					next_st.ptr = addr_i;
				end else if (!st.dir_known || play_record_select_i != st.play) begin
					next_st.ptr = '0;
				end else if (play_record_select_i && (addr_i[recorder_pkg::LOOP_BIT]
					|| (addr_i[recorder_pkg::LEVEL_BIT] && !addr_i[recorder_pkg::CHAIN_BIT]))) begin
					next_st.ptr = '0;
				end else if (!play_record_select_i && addr_i[recorder_pkg::MERGE_BIT]
					&& st.fsm == recorder_pkg::ST_IDLE && st.ptr != '0 && mk.rd_val) begin
					mk.wr_en = 1'b1;
					next_st.ptr = st.ptr - 1'b1;
				end
			end
		end else if (rise && st.fsm == recorder_pkg::ST_RUN && !bmode
			&& (!st.play || st.modes[recorder_pkg::LEVEL_BIT])) begin
			next_st.fsm = recorder_pkg::ST_IDLE;
			if (!st.play) begin
				mk.wr_en = 1'b1;
				mk.wr_val = 1'b1;
				next_st.ptr = ptr_inc;
			end
		end else if (row_tick) begin
			if (!st.play) begin
				mk.wr_en = 1'b1;
				if (at_end) begin
					next_st.ovf = 1'b1;
					next_st.fsm = recorder_pkg::ST_IDLE;
				end else begin
					next_st.ptr = ptr_inc;
				end
			end else if (mk.rd_val) begin
				if (st.modes[recorder_pkg::LOOP_BIT]) begin
					next_st.ptr = '0;
				end else if (bmode) begin
					next_st.fsm = recorder_pkg::ST_IDLE;
					next_st.ptr = ptr_inc;
				end else begin
					next_st.fsm = recorder_pkg::ST_IDLE;
					next_st.eom_hit = 1'b1;
					next_st.ptr = st.modes[recorder_pkg::CHAIN_BIT] ? ptr_inc : '0;
				end
			end else if (at_end) begin
				if (st.modes[recorder_pkg::LOOP_BIT]) begin
					next_st.ptr = '0;
				end else begin
					next_st.ovf = 1'b1;
					next_st.fsm = recorder_pkg::ST_IDLE;
				end
			end else begin
				next_st.ptr = ptr_inc;
			end
		end else if (st.fsm == recorder_pkg::ST_CUE) begin
			// Scan one row per clock; no audio is produced while cueing
			if (mk.rd_val) begin
				next_st.fsm = recorder_pkg::ST_IDLE;
				next_st.ptr = ptr_inc;
			end else if (at_end) begin
				next_st.ovf = 1'b1;
				next_st.fsm = recorder_pkg::ST_IDLE;
			end else begin
				next_st.ptr = ptr_inc;
			end
		end
		next_st.asleep = stop_reset_in_i | (st.asleep & ~fall)
			| (next_st.mode_use & next_st.modes[recorder_pkg::BUTTON_BIT]
			& (next_st.fsm == recorder_pkg::ST_IDLE) & start_strobe_n_i);
		next_st.eom_o = (next_st.mode_use && next_st.modes[recorder_pkg::BUTTON_BIT])
			? (next_st.fsm == recorder_pkg::ST_RUN) : ~next_st.eom_hit;
		next_st.ovf_n = ~next_st.ovf;

		////////////////////////////////////////////////////////////////////////
		// APB slave: data is prepared in the setup cycle, one access cycle
		next_st.pready = psel_i & ~penable_i;
		next_st.pslverr = 1'b0;
		if (psel_i && !penable_i) begin
			next_st.prdata = '0;
			unique case (paddr_i)
				recorder_pkg::STATUS_OFS: begin
					next_st.prdata[recorder_pkg::STAT_PTR_LSB +: AW] = st.ptr;
					next_st.prdata[recorder_pkg::STAT_RUN_BIT] = (st.fsm == recorder_pkg::ST_RUN);
					next_st.prdata[recorder_pkg::STAT_PLAY_BIT] = st.play;
					next_st.prdata[recorder_pkg::STAT_CUE_BIT] = (st.fsm == recorder_pkg::ST_CUE);
					next_st.prdata[recorder_pkg::STAT_EOM_BIT] = st.eom_hit;
					next_st.prdata[recorder_pkg::STAT_OVF_BIT] = st.ovf;
					next_st.prdata[recorder_pkg::STAT_SLEEP_BIT] = st.asleep;
					next_st.prdata[recorder_pkg::STAT_MODEUSE_BIT] = st.mode_use;
					next_st.prdata[recorder_pkg::STAT_MODES_LSB +: recorder_pkg::MODE_W] = st.modes;
				end
				recorder_pkg::CONFIG_OFS: begin
					next_st.prdata[AW-1:0] = st.mem_last;
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end
		if (psel_i && penable_i && st.pready && pwrite_i && paddr_i == recorder_pkg::CONFIG_OFS) begin
			// Last usable row; overflow and loop wrap use it
			next_st.mem_last = pwdata_i[AW-1:0];
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '{fsm: recorder_pkg::ST_IDLE, ptr: '0, mem_last: recorder_pkg::ROW_LAST_RST,
				modes: '0, mode_use: 1'b0, play: 1'b0, dir_known: 1'b0, asleep: 1'b1,
				eom_hit: 1'b0, ovf: 1'b0, tick: '0, eom_o: 1'b1, ovf_n: 1'b1,
				pready: 1'b0, pslverr: 1'b0, prdata: '0};
		end else begin
			st <= next_st;
		end
	end

	assign end_marker_out_o = st.eom_o;
	assign overflow_out_n_o = st.ovf_n;
	assign power_down_o = st.asleep;
	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_direct_addr_load: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		fall && !mu && !stop_reset_in_i |=> st.ptr == $past(addr_i) && !st.mode_use)
		else $error("direct address not loaded");

	a_dir_change_zero: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		fall && mu && !addr_i[6] && !stop_reset_in_i && play_record_select_i != st.play |=> st.ptr == '0)
		else $error("pointer kept across direction change");

	a_mode_latch_held: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		fall && !stop_reset_in_i |=> st.modes == ($past(mu) ? $past(addr_i[6:0]) : 7'h00)
			&& st.play == $past(play_record_select_i))
		else $error("mode or direction not latched at strobe fall");

	a_stop_pulse_reset: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		stop_reset_in_i |=> st.ptr == '0 && power_down_o && st.fsm == recorder_pkg::ST_IDLE)
		else $error("stop did not reset and power down");

	a_run_indicator: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		bmode |-> end_marker_out_o == (st.fsm == recorder_pkg::ST_RUN))
		else $error("run indicator wrong in button mode");

	a_level_play_stop: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		st.fsm == recorder_pkg::ST_RUN && st.play && st.modes[5] && !bmode && $rose(start_strobe_n_i)
			&& !stop_reset_in_i |=> st.fsm == recorder_pkg::ST_IDLE)
		else $error("level playback not stopped by strobe rise");

	a_loop_no_overflow: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		st.fsm == recorder_pkg::ST_RUN && st.play && st.modes[3] && !fall && !stop_reset_in_i
			|=> overflow_out_n_o)
		else $error("overflow flagged during loop playback");

	a_marker_no_chain: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		row_tick && st.play && mk.rd_val && !st.modes[3] && !st.modes[4] && !bmode && !fall
			&& !stop_reset_in_i && !(rise && st.modes[5]) |=> st.ptr == '0 && !end_marker_out_o)
		else $error("pointer not reset at end marker");

	a_cue_stop_mark: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		st.fsm == recorder_pkg::ST_CUE && mk.rd_val && !fall && !stop_reset_in_i
			|=> st.fsm == recorder_pkg::ST_IDLE && st.ptr != $past(st.ptr))
		else $error("cue did not stop past the marker");

	a_button_pause_keep: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		fall && bmode && mu && addr_i[6] && st.fsm == recorder_pkg::ST_RUN && st.play && !stop_reset_in_i
			|=> st.fsm == recorder_pkg::ST_IDLE && st.ptr == $past(st.ptr))
		else $error("pause lost the pointer");

	a_button_sleep: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		bmode && st.fsm == recorder_pkg::ST_IDLE && start_strobe_n_i |=> power_down_o)
		else $error("no power-down after button cycle");
endmodule

// File: recorder_ctrl_model.sv
// Purpose: Stands in for the controller that drives the recorder pins.
// Assumes: Every pin changes just after a rising edge of mclk_i.
// Notes: Strobe idles high; each fall has at least one high cycle before it.

module recorder_ctrl_model (
	input wire logic mclk_i,
	output logic [recorder_pkg::ADDR_W-1:0] addr_o,
	output logic start_strobe_n_o,
	output logic stop_reset_in_o,
	output logic play_record_select_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		addr_o = 10'h000;
		start_strobe_n_o = 1'b1;
		stop_reset_in_o = 1'b0;
		play_record_select_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Callers pass either a plain row or a mode word with permitted pairs only
	task automatic strobe_low(input logic [9:0] a, input logic pr);
		@(posedge mclk_i);
		addr_o <= a;
		play_record_select_o <= pr;
		start_strobe_n_o <= 1'b0;
	endtask

	// At least one high cycle follows, so the next fall is always seen
	task automatic strobe_high(input int n);
		@(posedge mclk_i);
		start_strobe_n_o <= 1'b1;
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic press(input logic [9:0] a, input logic pr);
		strobe_low(a, pr);
		strobe_high(2);
	endtask

	task automatic stop_pulse();
		@(posedge mclk_i);
		stop_reset_in_o <= 1'b1;
		@(posedge mclk_i);
		stop_reset_in_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
endmodule

// File: voice_recorder_mode_control_tb_top.sv
// Purpose: Self-checking bench for the recorder mode sequencer.
// Assumes: Short rows (ROWS clocks) so whole messages fit in a short run.
// Notes: Pointer and state are observed through the STATUS register.

module voice_recorder_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int ROWS = 8;
	logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pready_o, pslverr_o, err;
	logic [9:0] addr_i;
	logic start_strobe_n_i, stop_reset_in_i, play_record_select_i;
	logic end_marker_out_o, overflow_out_n_o, power_down_o;
	logic [9:0] p;
	int err_total = 0;
	int samples_checked = 0;

	voice_recorder_mode_control #(.ROW_CYCLES(ROWS)) i_dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.start_strobe_n_i(start_strobe_n_i), .stop_reset_in_i(stop_reset_in_i),
		.play_record_select_i(play_record_select_i), .end_marker_out_o(end_marker_out_o),
		.overflow_out_n_o(overflow_out_n_o), .power_down_o(power_down_o),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o)
	);

	recorder_ctrl_model i_ctl (
		.mclk_i(mclk_i), .addr_o(addr_i), .start_strobe_n_o(start_strobe_n_i),
		.stop_reset_in_o(stop_reset_in_i), .play_record_select_o(play_record_select_i)
	);

	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic end_sim();
		$display("Counts: checked=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// APB master: holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 20) begin
			err_total++;
			end_sim();
		end
	endtask

	task automatic status();
		apb(1'b0, recorder_pkg::STATUS_OFS, 32'h00000000);
	endtask

	task automatic chk_ptr(input logic [9:0] exp);
		status();
		check(32'(rd[9:0]), 32'(exp));
	endtask

	// A pin that never reaches its level counts as a failure and ends the run
	task automatic wait_pin(input logic sel_eom, input logic v);
		int n;
		n = 0;
		while (((sel_eom ? end_marker_out_o : overflow_out_n_o) !== v) && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		if (n >= 300) begin
			err_total++;
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h00000000;
		repeat (6) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		check(32'({end_marker_out_o, overflow_out_n_o, power_down_o}), 32'h7);
		apb(1'b0, recorder_pkg::CONFIG_OFS, 32'h00000000);
		check(rd, 32'(recorder_pkg::ROW_LAST_RST));
		apb(1'b0, 8'h08, 32'h00000000);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		done("reset");

		// Short records leave markers at rows 5 and 9
		i_ctl.press(10'h005, 1'b0);
		chk_ptr(10'h006);
		i_ctl.press(10'h009, 1'b0);
		chk_ptr(10'h00A);
		i_ctl.press(10'h003, 1'b1);
		wait_pin(1'b1, 1'b0);
		chk_ptr(10'h000);
		done("direct");

		i_ctl.press(10'h310, 1'b1);
		wait_pin(1'b1, 1'b0);
		chk_ptr(10'h006);
		i_ctl.press(10'h311, 1'b1);
		repeat (20) @(posedge mclk_i);
		chk_ptr(10'h00A);
		done("chain_cue");

		// Record after playback: direction change clears the pointer
		i_ctl.strobe_low(10'h300, 1'b0);
		repeat (2) @(posedge mclk_i);
		status();
		check(32'({rd[recorder_pkg::STAT_RUN_BIT], rd[recorder_pkg::STAT_PLAY_BIT], rd[9:0]}), 32'h800);
		i_ctl.strobe_high(2);
		chk_ptr(10'h001);
		done("direction");

		i_ctl.strobe_low(10'h320, 1'b1);
		repeat (2) @(posedge mclk_i);
		status();
		check(32'({rd[recorder_pkg::STAT_RUN_BIT], rd[recorder_pkg::STAT_PLAY_BIT]}), 32'h3);
		check(32'(rd[9:0]), 32'h0);
		check(32'({rd[recorder_pkg::STAT_MODEUSE_BIT], rd[30:24]}), 32'hA0);
		i_ctl.strobe_high(2);
		status();
		check(32'(rd[recorder_pkg::STAT_RUN_BIT]), 32'h0);
		done("level");

		// Marker at row 0 makes the loop wrap on every row
		i_ctl.press(10'h308, 1'b1);
		repeat (60) @(posedge mclk_i);
		status();
		check(32'({rd[recorder_pkg::STAT_RUN_BIT], overflow_out_n_o}), 32'h3);
		i_ctl.stop_pulse();
		check(32'(power_down_o), 32'h1);
		chk_ptr(10'h000);
		done("loop");

		apb(1'b1, recorder_pkg::CONFIG_OFS, 32'h0000000F);
		apb(1'b0, recorder_pkg::CONFIG_OFS, 32'h00000000);
		check(32'(rd[9:0]), 32'hF);
		i_ctl.strobe_low(10'h00C, 1'b0);
		wait_pin(1'b0, 1'b0);
		check(32'(overflow_out_n_o), 32'h0);
		i_ctl.strobe_high(2);
		i_ctl.stop_pulse();
		check(32'(overflow_out_n_o), 32'h1);
		done("overflow");

		// Push-button record: start, pause, resume, stop
		i_ctl.press(10'h340, 1'b0);
		check(32'(end_marker_out_o), 32'h1);
		repeat (20) @(posedge mclk_i);
		i_ctl.press(10'h340, 1'b0);
		check(32'({end_marker_out_o, power_down_o}), 32'h1);
		status();
		p = rd[9:0];
		check(32'(p != 10'h000), 32'h1);
		i_ctl.press(10'h340, 1'b0);
		check(32'(end_marker_out_o), 32'h1);
		status();
		check(32'(rd[9:0]), 32'(p));
		i_ctl.stop_pulse();
		check(32'({end_marker_out_o, power_down_o}), 32'h1);
		chk_ptr(10'h000);
		done("button");

		// Push-button playback paused after one row, then resumed
		i_ctl.press(10'h340, 1'b1);
		repeat (8) @(posedge mclk_i);
		i_ctl.press(10'h340, 1'b1);
		check(32'({end_marker_out_o, power_down_o}), 32'h1);
		chk_ptr(10'h001);
		i_ctl.press(10'h340, 1'b1);
		check(32'(end_marker_out_o), 32'h1);
		i_ctl.stop_pulse();
		done("button_play");

		// Merge: the second take erases the first marker and starts on its row
		i_ctl.press(10'h302, 1'b0);
		chk_ptr(10'h001);
		i_ctl.press(10'h302, 1'b0);
		chk_ptr(10'h001);
		done("merge");

		// Level strobe with chain: a new low level continues from the pointer
		i_ctl.strobe_low(10'h330, 1'b1);
		repeat (12) @(posedge mclk_i);
		i_ctl.strobe_high(2);
		i_ctl.strobe_low(10'h330, 1'b1);
		repeat (2) @(posedge mclk_i);
		chk_ptr(10'h001);
		i_ctl.strobe_high(2);
		done("level_chain");
		end_sim();
	end
endmodule
